// >>> rtl/psdm_mapper.sv
`timescale 1ns/1ps
`default_nettype none
`include "psdm_map.svh"

// What this block does
// - Program counter steps by two per 24-bit program word.
// - Table address is page register over the 16-bit data address.
// - Low table read, word mode, returns program bits 15..0.
// - Low table read, byte mode, select picks bits 7..0 or 15..8.
// - High table read, word mode, gives bits 23..16 with upper byte zero.
// - High table read, byte mode, gives bits 23..16 or zero byte.
// - Only high table operations reach program bits 23..16 as data.
// - Redirect to program space only with address MSB and visibility enable set.
// - Visibility address is zero, visibility page, then low 15 address bits.
// - Visibility reads deliver only the low 16 bits of the program word.
// - Visibility redirection is suspended during table reads and writes.
// - Outside repeat, move, double move, prefetch MAC visibility access adds one cycle.
// - Outside repeat, other visibility accesses add two cycles.
// - In repeat, first, last, interrupt exit and re-entry add two cycles.
// - Other repeat iterations with visibility access add no cycles.
// - Y region is a contiguous subset of X region.
// - Outside dual-operand MAC, X covers the whole 256-byte space.
// - Dual-operand MAC reads exclude Y from X; writes use combined space.
// - MAC reads reach Y only by Y pointers, X only by X pointers.
// - Out-of-region MAC fetch or unimplemented address reads as zero.
module psdm_mapper
    import psdm_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        reqValid,
    input  wire psdm_kind_t  reqKind,
    input  wire logic        byteMode,
    input  wire logic [15:0] effAddr,
    input  wire logic [15:0] wrData,
    input  wire logic        macRead,
    input  wire psdm_ptr_t   macPtr,
    input  wire logic        shortClass,
    input  wire logic        repeatActive,
    input  wire logic        repeatFirst,
    input  wire logic        repeatLast,
    input  wire logic        repeatIntExit,
    input  wire logic        repeatReentry,
    input  wire logic        pcLoad,
    input  wire logic [22:0] pcLoadAddr,
    input  wire logic [23:0] progData,
    input  wire logic [15:0] ramData,
    output logic [22:0]      pc,
    output logic [23:0]      progAddr,
    output logic             progRd,
    output logic             progWr,
    output logic [2:0]       progWrEn,
    output logic [23:0]      progWrData,
    output logic [15:0]      dataAddr,
    output logic             dataRd,
    output logic             dataWr,
    output logic [1:0]       dataWrEn,
    output logic [15:0]      dataWrData,
    output logic [1:0]       stallCycles,
    output logic [15:0]      result,
    output logic             resultValid
);

    // =================================================================
    // Helper functions.
    function automatic logic regionOk(input logic [15:0] a, input logic mac,
                                      input psdm_ptr_t p);
        logic inY;
        inY = (a >= `PSDM_Y_BASE);
        if (a >= `PSDM_DATA_SIZE)
            regionOk = 1'b0;
        else if (!mac)
            regionOk = 1'b1;
        else if (p == PSDM_Y_POINTER_A || p == PSDM_Y_POINTER_B)
            regionOk = inY;
        else
            regionOk = !inY;
    endfunction

    function automatic logic [15:0] fmtProg(input psdm_kind_t k, input logic bm,
                                            input logic sel, input logic [23:0] p);
        if (k == PSDM_TABLE_READ_HIGH)
            fmtProg = (bm && sel) ? 16'h0000 : {8'h00, p[23:16]};
        else if (bm)
            fmtProg = {8'h00, sel ? p[15:8] : p[7:0]};
        else
            fmtProg = p[15:0];
    endfunction

    function automatic logic [1:0] penalty(input logic sc, input logic rpt,
                                           input logic edgeIter);
        if (!rpt)
            penalty = sc ? `PSDM_PEN_SHORT : `PSDM_PEN_LONG;
        else
            penalty = edgeIter ? `PSDM_PEN_LONG : `PSDM_PEN_NONE;
    endfunction

    // =================================================================
    // Register bus.
    logic [7:0]  tablePage;
    logic [7:0]  visPage;
    logic        visEn;
    logic [31:0] next_readdata;

    wire busReq  = (avs_read || avs_write) && avs_waitrequest;
    wire busWr   = avs_write && !avs_waitrequest;
    wire wrTable = busWr && avs_byteenable[0] && avs_address == `PSDM_OFF_TABLE_PAGE;
    wire wrVis   = busWr && avs_byteenable[0] && avs_address == `PSDM_OFF_VIS_PAGE;
    wire wrCtl   = busWr && avs_byteenable[0] && avs_address == `PSDM_OFF_CORE_CTRL;

    always_comb begin
        case (avs_address)
            `PSDM_OFF_TABLE_PAGE: next_readdata = {24'h000000, tablePage};
            `PSDM_OFF_VIS_PAGE:   next_readdata = {24'h000000, visPage};
            `PSDM_OFF_CORE_CTRL:  next_readdata = {31'h00000000, visEn};
            `PSDM_OFF_STATUS:     next_readdata = {8'h00, progAddr};
            default:              next_readdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else begin
            avs_waitrequest <= !busReq;
            if (busReq && avs_read)
                avs_readdata <= next_readdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tablePage <= `PSDM_RST_TABLE_PAGE;
            visPage   <= `PSDM_RST_VIS_PAGE;
            visEn     <= `PSDM_RST_VIS_EN;
        end else begin
            if (wrTable)
                tablePage <= avs_writedata[7:0];
            if (wrVis)
                visPage <= avs_writedata[7:0];
            if (wrCtl)
                visEn <= avs_writedata[`PSDM_VIS_EN_BIT];
        end
    end

    // =================================================================
    // Request decode.
    wire isFetch  = reqValid && reqKind == PSDM_FETCH;
    wire isDRd    = reqValid && reqKind == PSDM_DATA_READ;
    wire isDWr    = reqValid && reqKind == PSDM_DATA_WRITE;
    wire isTRdL   = reqValid && reqKind == PSDM_TABLE_READ_LOW;
    wire isTRdH   = reqValid && reqKind == PSDM_TABLE_READ_HIGH;
    wire isTWrL   = reqValid && reqKind == PSDM_TABLE_WRITE_LOW;
    wire isTWrH   = reqValid && reqKind == PSDM_TABLE_WRITE_HIGH;
    wire isTable  = isTRdL || isTRdH || isTWrL || isTWrH;
    // Table operations never take the visibility path.
    wire psvHit   = (isDRd || isDWr) && !isTable && effAddr[`PSDM_EA_MSB] && visEn;
    wire psvRd    = psvHit && isDRd;
    wire ramOk    = regionOk(effAddr, macRead && isDRd, macPtr);
    wire byteSel  = effAddr[0];
    wire edgeIter = repeatFirst || repeatLast || repeatIntExit || repeatReentry;

    wire [23:0] fetchAddr = {1'b0, pc[22:1], 1'b0};
    wire [23:0] tableAddr = {tablePage, effAddr};
    wire [23:0] visAddr   = {1'b0, visPage, effAddr[14:0]};

    // Low operations touch only bits 15..0, high ones only bits 23..16.
    wire [2:0]  twEnLow   = byteMode ? (byteSel ? 3'h2 : 3'h1) : 3'h3;
    wire [2:0]  twEnHigh  = (byteMode && byteSel) ? 3'h0 : 3'h4;
    wire [23:0] twDataLow = byteMode ? {8'h00, wrData[7:0], wrData[7:0]}
                                     : {8'h00, wrData};
    wire [23:0] twDataHi  = {wrData[7:0], 16'h0000};
    wire [1:0]  dwEn      = byteMode ? (byteSel ? 2'h2 : 2'h1) : 2'h3;
    wire [15:0] dwData    = byteMode ? {wrData[7:0], wrData[7:0]} : wrData;

    // =================================================================
    // Program counter.
    always_ff @(posedge ref_clk) begin
        if (rst)
            pc <= `PSDM_RST_PC;
        else if (pcLoad)
            pc <= {pcLoadAddr[22:1], 1'b0};
        else if (isFetch)
            pc <= pc + `PSDM_PC_STEP;
    end

    // =================================================================
    // Address stage.
    psdm_kind_t pendKind;
    psdm_src_t  pendSrc;
    logic       pendValid;
    logic       pendByte;
    logic       pendSel;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            progAddr    <= 24'h000000;
            progRd      <= 1'b0;
            progWr      <= 1'b0;
            progWrEn    <= 3'h0;
            progWrData  <= 24'h000000;
            stallCycles <= `PSDM_PEN_NONE;
        end else begin
            progRd      <= isFetch || isTRdL || isTRdH || psvRd;
            progWr      <= isTWrL || isTWrH;
            progWrEn    <= isTWrL ? twEnLow : (isTWrH ? twEnHigh : 3'h0);
            progWrData  <= isTWrL ? twDataLow : twDataHi;
            stallCycles <= psvHit ? penalty(shortClass, repeatActive, edgeIter)
                                  : `PSDM_PEN_NONE;
            if (isFetch)
                progAddr <= fetchAddr;
            else if (isTable)
                progAddr <= tableAddr;
            else if (psvHit)
                progAddr <= visAddr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dataAddr   <= 16'h0000;
            dataRd     <= 1'b0;
            dataWr     <= 1'b0;
            dataWrEn   <= 2'h0;
            dataWrData <= 16'h0000;
        end else begin
            dataRd     <= isDRd && !psvHit && ramOk;
            dataWr     <= isDWr && !psvHit && ramOk;
            dataWrEn   <= dwEn;
            dataWrData <= dwData;
            if ((isDRd || isDWr) && !psvHit)
                dataAddr <= effAddr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pendValid <= 1'b0;
            pendKind  <= PSDM_FETCH;
            pendSrc   <= PSDM_SRC_ZERO;
            pendByte  <= 1'b0;
            pendSel   <= 1'b0;
        end else begin
            pendValid <= isDRd || isTRdL || isTRdH;
            pendKind  <= reqKind;
            pendByte  <= byteMode;
            pendSel   <= byteSel;
            if (isTRdL || isTRdH || psvRd)
                pendSrc <= PSDM_SRC_PROG;
            else if (ramOk)
                pendSrc <= PSDM_SRC_RAM;
            else
                pendSrc <= PSDM_SRC_ZERO;
        end
    end

    // =================================================================
    // Result stage.
    wire [15:0] ramByte = {8'h00, pendSel ? ramData[15:8] : ramData[7:0]};
    wire [15:0] ramFmt  = pendByte ? ramByte : ramData;
    // Visibility reads format as low table reads, word or byte, so bits 23..16 never appear.
    wire [15:0] progFmt = fmtProg(pendKind, pendByte, pendSel, progData);
    wire [15:0] next_result = (pendSrc == PSDM_SRC_PROG) ? progFmt :
                              (pendSrc == PSDM_SRC_RAM)  ? ramFmt  : 16'h0000;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            result      <= 16'h0000;
            resultValid <= 1'b0;
        end else begin
            resultValid <= pendValid;
            if (pendValid)
                result <= next_result;
        end
    end

    // =================================================================
    // Checks.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence seqHighWord;
        isTRdH && !byteMode;
    endsequence

    sequence seqLowWord;
        isTRdL && !byteMode;
    endsequence

    sequence seqMacCross;
        isDRd && macRead && !psvHit && effAddr < `PSDM_DATA_SIZE &&
        (macPtr == PSDM_X_POINTER_A || macPtr == PSDM_X_POINTER_B) &&
        effAddr >= `PSDM_Y_BASE;
    endsequence

    sequence seqLowByte;
        isTRdL && byteMode;
    endsequence

    sequence seqHighByte;
        isTRdH && byteMode;
    endsequence

    AST_PC_STEP: assert property (isFetch && !pcLoad |=> pc == $past(pc) + `PSDM_PC_STEP)
        else $error("Program counter did not step by two.");
    AST_TABLE_ADDR: assert property (isTable |=>
        progAddr == {$past(tablePage), $past(effAddr)})
        else $error("Table address not built from page and data address.");
    AST_LOW_WORD: assert property (seqLowWord ##2 1 |-> resultValid &&
        result == $past(progData[15:0]))
        else $error("Low word table read returned wrong data.");
    AST_HIGH_WORD: assert property (seqHighWord |-> ##2 resultValid &&
        result == {8'h00, $past(progData[23:16])})
        else $error("High word table read upper byte not zero.");
    AST_NO_REDIRECT: assert property (isDRd && !(effAddr[15] && visEn) |=> !progRd)
        else $error("Data read redirected without visibility enable.");
    AST_VIS_ADDR: assert property (psvRd |=> progRd &&
        progAddr == {1'b0, $past(visPage), $past(effAddr[14:0])})
        else $error("Visibility address wrongly formed.");
    AST_SHORT_PEN: assert property (psvHit && !repeatActive && shortClass |=>
        stallCycles == `PSDM_PEN_SHORT)
        else $error("Short class visibility access not one extra cycle.");
    AST_REPEAT_PEN: assert property (psvHit && repeatActive |=>
        stallCycles == ($past(edgeIter) ? `PSDM_PEN_LONG : `PSDM_PEN_NONE))
        else $error("Repeat loop visibility penalty wrong.");
    AST_MAC_ZERO: assert property (seqMacCross |-> ##1 !dataRd ##1
        resultValid && result == 16'h0000)
        else $error("Cross-region multiply-accumulate fetch not zero.");
    AST_BUS_WAIT: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("Register read not answered in one cycle.");

    AST_LOW_BYTE: assert property (seqLowByte |-> ##2 resultValid && result ==
        {8'h00, $past(effAddr[0], 2) ? $past(progData[15:8]) : $past(progData[7:0])})
        else $error("Low byte table read returned wrong byte.");
    AST_HIGH_BYTE: assert property (seqHighByte |-> ##2 resultValid && result ==
        ($past(effAddr[0], 2) ? 16'h0000 : {8'h00, $past(progData[23:16])}))
        else $error("High byte table read returned wrong byte.");

    AST_VIS_DATA: assert property (psvRd && !byteMode |-> ##2 result ==
        $past(progData[15:0]))
        else $error("Visibility read did not return the low program word.");
    AST_LONG_PEN: assert property (psvHit && !repeatActive && !shortClass |=>
        stallCycles == `PSDM_PEN_LONG)
        else $error("Other class visibility access not two extra cycles.");
    AST_PSV_SUSPEND: assert property (isTable && effAddr[15] && visEn |=>
        progAddr == {$past(tablePage), $past(effAddr)})
        else $error("Table operation took the visibility path.");

    AST_TW_LOW: assert property (isTWrL |=> progWr && !progWrEn[2])
        else $error("Low table write reached the upper program byte.");
    AST_TW_HIGH: assert property (isTWrH |=> progWr && progWrEn[1:0] == 2'h0)
        else $error("High table write reached the low program word.");

    AST_X_FULL: assert property (isDRd && !macRead && !psvHit &&
        effAddr < `PSDM_DATA_SIZE |=> dataRd)
        else $error("Plain read inside data space not served.");
    AST_MAC_WRITE: assert property (isDWr && !psvHit && effAddr < `PSDM_DATA_SIZE |=>
        dataWr)
        else $error("Data write inside data space dropped.");
    AST_Y_ONLY: assert property (isDRd && macRead && effAddr < `PSDM_Y_BASE &&
        (macPtr == PSDM_Y_POINTER_A || macPtr == PSDM_Y_POINTER_B) |=> !dataRd)
        else $error("Y pointer read served from X region.");
    AST_UNIMPL: assert property (isDRd && !psvHit && effAddr >= `PSDM_DATA_SIZE |->
        ##2 resultValid && result == 16'h0000)
        else $error("Unimplemented address did not read as zero.");

endmodule // psdm_mapper
`default_nettype wire

// >>> rtl/psdm_map.svh
`ifndef PSDM_MAP_SVH
`define PSDM_MAP_SVH
// =====================================================================
// Register offsets, byte addresses on the register bus.
`define PSDM_OFF_TABLE_PAGE  4'h0
`define PSDM_OFF_VIS_PAGE    4'h4
`define PSDM_OFF_CORE_CTRL   4'h8
`define PSDM_OFF_STATUS      4'hC
// =====================================================================
// Field positions and reset values.
`define PSDM_VIS_EN_BIT      0
`define PSDM_CFG_SPACE_BIT   7
`define PSDM_EA_MSB          15
`define PSDM_RST_TABLE_PAGE  8'h00
`define PSDM_RST_VIS_PAGE    8'h00
`define PSDM_RST_VIS_EN      1'b0
`define PSDM_RST_PC          23'h000000
// =====================================================================
// Program counter step and data space layout.
`define PSDM_PC_STEP         23'h000002
`define PSDM_DATA_SIZE       16'h0100
`define PSDM_Y_BASE          16'h0080
// =====================================================================
// Extra instruction cycles for visibility accesses.
`define PSDM_PEN_NONE        2'h0
`define PSDM_PEN_SHORT       2'h1
`define PSDM_PEN_LONG        2'h2
`endif

// >>> rtl/psdm_pkg.sv
package psdm_pkg;
    // =================================================================
    // Access kinds presented by the core.
    typedef enum logic [2:0] {
        PSDM_FETCH            = 3'h0,
        PSDM_DATA_READ        = 3'h1,
        PSDM_DATA_WRITE       = 3'h2,
        PSDM_TABLE_READ_LOW   = 3'h3,
        PSDM_TABLE_READ_HIGH  = 3'h4,
        PSDM_TABLE_WRITE_LOW  = 3'h5,
        PSDM_TABLE_WRITE_HIGH = 3'h6
    } psdm_kind_t;
    // =================================================================
    // Operand pointers of the dual-operand multiply-accumulate class.
    typedef enum logic [1:0] {
        PSDM_X_POINTER_A = 2'h0,
        PSDM_X_POINTER_B = 2'h1,
        PSDM_Y_POINTER_A = 2'h2,
        PSDM_Y_POINTER_B = 2'h3
    } psdm_ptr_t;
    // =================================================================
    // Source of the read result.
    typedef enum logic [1:0] {
        PSDM_SRC_PROG = 2'h0,
        PSDM_SRC_RAM  = 2'h1,
        PSDM_SRC_ZERO = 2'h2
    } psdm_src_t;
endpackage

// >>> tb/psdm_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Program memory and data RAM answering in the cycle of the read strobe.
module psdm_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        progRd,
    input  wire logic [23:0] progAddr,
    input  wire logic        dataRd,
    input  wire logic [15:0] dataAddr,
    output logic      [23:0] progData,
    output logic      [15:0] ramData
);
    logic [23:0] noise = 24'h5A5A5A;
    function automatic logic [23:0] progWord(input logic [23:0] a);
        return {a[8:1] ^ 8'hA5, a[16:1] ^ 16'h3C96};
    endfunction
    function automatic logic [15:0] ramWord(input logic [15:0] a);
        return {a[8:1], ~a[8:1]} ^ 16'h1234;
    endfunction
    // Released buses show a changing pattern instead of the last word.
    always @(posedge ref_clk) noise <= ~noise ^ 24'h00F00F;
    assign progData = progRd ? progWord(progAddr) : noise;
    assign ramData  = dataRd ? ramWord(dataAddr) : noise[15:0];
endmodule // psdm_mem_model
`default_nettype wire

// >>> tb/program_space_data_access_mapper_tb.sv
`timescale 1ns/1ps
`default_nettype none
module program_space_data_access_mapper_tb
    import psdm_pkg::*;
;
    logic        ref_clk, rst, avs_read, avs_write, avs_waitrequest, reqValid, byteMode;
    logic        macRead, shortClass, pcLoad, resultValid, progRd, progWr, dataRd, dataWr;
    logic        repeatActive, repeatFirst, repeatLast, repeatIntExit, repeatReentry, ve;
    logic [3:0]  avs_address, avs_byteenable, rf;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [2:0]  progWrEn;
    logic [1:0]  dataWrEn, stallCycles;
    logic [15:0] effAddr, wrData, ramData, dataAddr, dataWrData, result;
    logic [22:0] pcLoadAddr, pc;
    logic [23:0] progData, progAddr, progWrData;
    logic [7:0]  tp, vp;
    psdm_kind_t  reqKind;
    psdm_ptr_t   macPtr;
    int          fails, n_checks, seed, i, j;
    // ==========================================
    // Clock, design and memory model.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    psdm_mapper dut (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .reqValid, .reqKind, .byteMode,
        .effAddr, .wrData, .macRead, .macPtr, .shortClass, .repeatActive, .repeatFirst,
        .repeatLast, .repeatIntExit, .repeatReentry, .pcLoad, .pcLoadAddr, .progData,
        .ramData, .pc, .progAddr, .progRd, .progWr, .progWrEn, .progWrData, .dataAddr,
        .dataRd, .dataWr, .dataWrEn, .dataWrData, .stallCycles, .result, .resultValid);
    psdm_mem_model mem (.ref_clk, .progRd, .progAddr, .dataRd, .dataAddr, .progData, .ramData);
    // ==========================================
    // Checking and bus tasks.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic avm(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        if (n >= 50) chk(1'b1, 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic core(input psdm_kind_t k, input logic bm, input logic [15:0] ea);
        logic [23:0] a, w, twd, twm;
        logic [15:0] r, exp, d, dwm;
        logic [2:0]  twe;
        logic [1:0]  st, dwe;
        logic        tbl, vis, bad, prd;
        d = 16'($random(seed));
        @(posedge ref_clk);
        reqValid <= 1'b1;
        reqKind <= k;
        byteMode <= bm;
        effAddr <= ea;
        wrData <= d;
        @(posedge ref_clk);
        reqValid <= 1'b0;
        #1;
        tbl = k inside {PSDM_TABLE_READ_LOW, PSDM_TABLE_READ_HIGH,
                        PSDM_TABLE_WRITE_LOW, PSDM_TABLE_WRITE_HIGH};
        vis = !tbl && ve && ea[15] && k != PSDM_FETCH;
        a = tbl ? {tp, ea} : {1'b0, vp, ea[14:0]};
        w = mem.progWord(a);
        r = mem.ramWord(ea);
        bad = ea >= 16'h0100 || (macRead && (macPtr[1] != ea[7]));
        st = !vis ? 2'h0 : !repeatActive ? (shortClass ? 2'h1 : 2'h2)
           : (repeatFirst | repeatLast | repeatIntExit | repeatReentry) ? 2'h2 : 2'h0;
        case (k)
            PSDM_TABLE_READ_LOW: exp = !bm ? w[15:0] : {8'h00, ea[0] ? w[15:8] : w[7:0]};
            PSDM_TABLE_READ_HIGH: exp = (bm && ea[0]) ? 16'h0000 : {8'h00, w[23:16]};
            default: exp = vis ? w[15:0] : bad ? 16'h0000
                         : !bm ? r : {8'h00, ea[0] ? r[15:8] : r[7:0]};
        endcase
        dwe = bm ? (ea[0] ? 2'h2 : 2'h1) : 2'h3;
        dwm = {{8{dwe[1]}}, {8{dwe[0]}}};
        twe = (k == PSDM_TABLE_WRITE_HIGH) ? ((bm && ea[0]) ? 3'h0 : 3'h4) : {1'b0, dwe};
        twm = {{8{twe[2]}}, {8{twe[1]}}, {8{twe[0]}}};
        twd = (k == PSDM_TABLE_WRITE_HIGH) ? {d[7:0], 16'h0000}
                                           : {8'h00, bm ? {2{d[7:0]}} : d};
        prd = (vis && k == PSDM_DATA_READ) ||
              k inside {PSDM_FETCH, PSDM_TABLE_READ_LOW, PSDM_TABLE_READ_HIGH};
        chk(stallCycles, st);
        if (tbl || vis) chk(progAddr, a);
        chk(progRd, prd);
        chk(dataRd, k == PSDM_DATA_READ && !vis && !bad);
        chk(dataWr, k == PSDM_DATA_WRITE && !vis && !bad);
        chk(progWr, k inside {PSDM_TABLE_WRITE_LOW, PSDM_TABLE_WRITE_HIGH});
        if (k inside {PSDM_TABLE_WRITE_LOW, PSDM_TABLE_WRITE_HIGH}) begin
            chk(progWrEn, twe);
            chk(progWrData & twm, twd & twm);
        end
        if (k inside {PSDM_DATA_READ, PSDM_DATA_WRITE} && !vis) chk(dataAddr, ea);
        if (k == PSDM_DATA_WRITE) begin
            chk(dataWrEn, dwe);
            chk(dataWrData & dwm, (bm ? {2{d[7:0]}} : d) & dwm);
        end
        @(posedge ref_clk);
        #1;
        if (k inside {PSDM_DATA_READ, PSDM_TABLE_READ_LOW, PSDM_TABLE_READ_HIGH}) begin
            chk(resultValid, 1'b1);
            chk(result, exp);
        end
    endtask
    // ==========================================
    // Main sequence.
    initial begin
        seed = 32'ha5339d7e;
        {rst, avs_read, avs_write, reqValid, byteMode, macRead, shortClass, pcLoad} = 8'hFF & 8'h80;
        {repeatActive, repeatFirst, repeatLast, repeatIntExit, repeatReentry} = 5'h00;
        {avs_address, avs_writedata, effAddr, wrData, pcLoadAddr} = '0;
        avs_byteenable = 4'hF;
        reqKind = PSDM_FETCH;
        macPtr = PSDM_X_POINTER_A;
        {tp, vp, ve} = '0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        for (i = 0; i < 5; i++) begin
            avm(1'b0, 4'(i * 4 + (i / 4) * 2 - (i / 4) * 16), 32'h0, rd);
            chk(rd, 32'h0);
        end
        tp = 8'h3C;
        vp = 8'h5A;
        ve = 1'b1;
        avm(1'b1, 4'h0, {24'hFFFFFF, tp}, rd);
        avm(1'b1, 4'h4, {24'h0, vp}, rd);
        avm(1'b1, 4'h8, 32'h1, rd);
        avs_byteenable <= 4'hE;
        avm(1'b1, 4'h4, 32'hFF, rd);
        avs_byteenable <= 4'hF;
        for (i = 0; i < 3; i++) begin
            avm(1'b0, 4'(i * 4), 32'h0, rd);
            chk(rd, {24'h0, i == 0 ? tp : i == 1 ? vp : {7'h0, ve}});
        end
        @(posedge ref_clk);
        pcLoad <= 1'b1;
        pcLoadAddr <= 23'h000101;
        @(posedge ref_clk);
        pcLoad <= 1'b0;
        for (j = 0; j < 3; j++) begin
            core(PSDM_FETCH, 1'b0, 16'h0000);
            chk(progAddr, 24'h000100 + 24'(2 * j));
            chk(pc, 23'h000102 + 23'(2 * j));
        end
        for (j = 0; j < 2; j++) begin
            tp = j ? 8'h83 : 8'h3C;
            avm(1'b1, 4'h0, {24'h0, tp}, rd);
            for (i = 0; i < 24; i++)
                core(psdm_kind_t'(i < 16 ? 3 + i[0] : 5 + i[0]), i[1], 16'($random(seed)));
            core(PSDM_TABLE_READ_LOW, 1'b0, 16'h8002);
        end
        avm(1'b0, 4'hC, 32'h0, rd);
        chk(rd, {8'h00, tp, 16'h8002});
        for (i = 0; i < 12; i++) begin
            rf = (i >= 4) ? 4'h1 << (i / 2 - 2) : 4'h0;
            @(posedge ref_clk);
            shortClass <= i[0];
            repeatActive <= (i >= 2);
            {repeatReentry, repeatIntExit, repeatLast, repeatFirst} <= rf;
            core(PSDM_DATA_READ, 1'b0, {1'b1, 15'($random(seed))});
        end
        ve = 1'b0;
        avm(1'b1, 4'h8, 32'h0, rd);
        core(PSDM_DATA_READ, 1'b0, 16'h8010);
        ve = 1'b1;
        avm(1'b1, 4'h8, 32'h1, rd);
        core(PSDM_DATA_WRITE, 1'b0, 16'h8010);
        core(PSDM_DATA_WRITE, 1'b1, 16'h0091);
        core(PSDM_DATA_WRITE, 1'b0, 16'h0120);
        @(posedge ref_clk);
        {repeatActive, repeatReentry, repeatIntExit, repeatLast, repeatFirst} <= 5'h00;
        for (i = 0; i < 17; i++) begin
            @(posedge ref_clk);
            macRead <= i[3] && i < 16;
            macPtr <= psdm_ptr_t'(i[1:0]);
            core(PSDM_DATA_READ, !i[3] && i[0],
                 i == 16 ? 16'h0100 : 16'({i[2], 7'($random(seed))}) & 16'h00FE);
        end
        give_verdict;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        give_verdict;
    end
endmodule // program_space_data_access_mapper_tb
`default_nettype wire
